// ### common/window_det_pkg.sv
// Constants shared by the converter result window detector.
package window_det_pkg;

	// ----------------------------------------------------------------
	// Register addresses on the special-function-register bus.
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONFIG      = 8'hBC;
	localparam logic [7:0] ADDR_RESULT_LOW  = 8'hBD;
	localparam logic [7:0] ADDR_RESULT_HIGH = 8'hBE;
	localparam logic [7:0] ADDR_LOWER_LOW   = 8'hC3;
	localparam logic [7:0] ADDR_LOWER_HIGH  = 8'hC4;
	localparam logic [7:0] ADDR_UPPER_LOW   = 8'hC5;
	localparam logic [7:0] ADDR_UPPER_HIGH  = 8'hC6;
	localparam logic [7:0] ADDR_CONTROL     = 8'hE8;

	// ----------------------------------------------------------------
	// Reset values.
	// ----------------------------------------------------------------
	localparam logic [7:0] RESET_BYTE       = 8'h00;
	localparam logic [7:0] RESET_CONFIG     = 8'hF8;
	localparam logic [7:0] READ_UNMAPPED    = 8'h00;

	// ----------------------------------------------------------------
	// Field positions.
	// ----------------------------------------------------------------
	localparam int CTRL_ENABLE_BIT  = 7;
	localparam int CTRL_TRACK_BIT   = 6;
	localparam int CTRL_DONE_BIT    = 5;
	localparam int CTRL_BUSY_BIT    = 4;
	localparam int CTRL_WINDOW_BIT  = 3;
	localparam int CFG_JUSTIFY_BIT  = 2;
	localparam int CFG_DIVIDER_LSB  = 3;
	localparam int RESULT_MSB_BIT   = 9;
	localparam int RESULT_WIDTH     = 10;
	localparam int LEFT_PAD_WIDTH   = 6;

	// ----------------------------------------------------------------
	// Conversion timing in converter clocks.
	// ----------------------------------------------------------------
	localparam logic [3:0] CONVERT_CLOCKS   = 4'hA;
	localparam logic [3:0] TRACK_CLOCKS     = 4'h3;
	localparam logic [2:0] START_ON_WRITE   = 3'h0;

	// Conversion sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b01,
		ST_CONVERT = 2'b10
	} seq_state_t;

endpackage

// ### common/result_if.sv
// Carrier between the result formatter and the window comparator.
`timescale 1ns/10ps
interface result_if;
	logic [15:0] word;
	logic [15:0] upper;
	logic [15:0] lower;
	logic        diff;
	logic        match;

	modport source  (output word, output upper, output lower, output diff, input match);
	modport compare (input word, input upper, input lower, input diff, output match);
endinterface

// ### hw/window_compare.sv
// Signed or unsigned window comparison of one result word against two limits.
`timescale 1ns/10ps
module window_compare (
	result_if.compare cmp
);

	logic gt_lower;
	logic lt_lower;
	logic gt_upper;
	logic lt_upper;
	logic upper_above;

	// --------------------------------------------------------------
	// Comparison
	// --------------------------------------------------------------

	// Differential words compare as two's complement, single-ended as unsigned.
	always_comb begin
		if (cmp.diff) begin
			gt_lower    = $signed(cmp.word) > $signed(cmp.lower);
			lt_lower    = $signed(cmp.word) < $signed(cmp.lower);
			gt_upper    = $signed(cmp.word) > $signed(cmp.upper);
			lt_upper    = $signed(cmp.word) < $signed(cmp.upper);
			upper_above = $signed(cmp.upper) > $signed(cmp.lower);
		end else begin
			gt_lower    = cmp.word > cmp.lower;
			lt_lower    = cmp.word < cmp.lower;
			gt_upper    = cmp.word > cmp.upper;
			lt_upper    = cmp.word < cmp.upper;
			upper_above = cmp.upper > cmp.lower;
		end
		// Limit order selects inside or outside detection.
		// With swapped limits the upper register is the smaller bound, so an
		// outside match is a word below the upper or above the lower register.
		if (upper_above) begin
			cmp.match = gt_lower && lt_upper;
		end else begin
			cmp.match = lt_upper || gt_lower;
		end
	end

endmodule // window_compare

// ### hw/adc_result_window_detector.sv
// Converter result registers, conversion sequencer and window detector registers.
//
// Summary of operation
// - The upper limit is a 16-bit read/write pair of byte registers that reset to zero.
// - Single-ended results compare as unsigned, and right-justified ones are sign-extended from code bit nine.
// - Differential results are 10-bit two's complement values and compare as signed.
// - When the upper limit exceeds the lower, a match needs lower < result < upper.
// - With the limits swapped, a match needs result below the upper or above the lower limit.
// - In differential mode the full 16-bit words compare signed, so all ones is minus one.
// - A conversion lasts at least ten converter clocks before a new result appears.
// - A match sets bit three of the control register, which holds until software clears it.
// - The lower limit is a 16-bit read/write pair of byte registers at their own addresses.
// - Right-justified results copy bit one of the high byte into its bits seven to two.
`timescale 1ns/10ps
module adc_result_window_detector (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic [7:0] sfr_addr_in,
	input  wire logic [7:0] sfr_wdata_in,
	input  wire logic       sfr_wr_in,
	input  wire logic       sfr_rd_in,
	output logic      [7:0] sfr_rdata_out,
	input  wire logic       conv_start_in,
	input  wire logic       diff_mode_in,
	input  wire logic [9:0] sample_in,
	output logic            busy_out,
	output logic            window_match_out
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [7:0] window_upper_limit_high;
	logic [7:0] window_upper_limit_low;
	logic [7:0] window_lower_limit_high;
	logic [7:0] window_lower_limit_low;
	logic [7:0] result_high_byte;
	logic [7:0] result_low_byte;
	logic [4:0] divider;
	logic       left_justify_select;
	logic       enable;
	logic       track_mode;
	logic [2:0] start_mode;
	logic       done_flag;
	logic       window_match_flag;
	logic [7:0] rdata;

	logic [7:0] next_window_upper_limit_high;
	logic [7:0] next_window_upper_limit_low;
	logic [7:0] next_window_lower_limit_high;
	logic [7:0] next_window_lower_limit_low;
	logic [7:0] next_result_high_byte;
	logic [7:0] next_result_low_byte;
	logic [4:0] next_divider;
	logic       next_left_justify_select;
	logic       next_enable;
	logic       next_track_mode;
	logic [2:0] next_start_mode;
	logic       next_done_flag;
	logic       next_window_match_flag;
	logic [7:0] next_rdata;

	window_det_pkg::seq_state_t state;
	window_det_pkg::seq_state_t next_state;
	logic [4:0]                 div_count;
	logic [4:0]                 next_div_count;
	logic [3:0]                 clock_count;
	logic [3:0]                 next_clock_count;

	logic        write_control;
	logic        start_request;
	logic        sar_tick;
	logic [3:0]  clocks_needed;
	logic        finish;
	logic [15:0] formatted;

	result_if cmp_bus ();

	window_compare compare_unit (
		.cmp (cmp_bus.compare)
	);

	// ----------------------------------------------------------------
	// Result formatting and comparator hookup
	// ----------------------------------------------------------------

	// The word about to be stored is what the comparator judges.
	always_comb begin
		if (left_justify_select) begin
			formatted = {sample_in, {window_det_pkg::LEFT_PAD_WIDTH{1'b0}}};
		end else begin
			formatted = {{window_det_pkg::LEFT_PAD_WIDTH{sample_in[9]}}, sample_in};
		end
	end

	assign cmp_bus.word  = formatted;
	assign cmp_bus.upper = {window_upper_limit_high, window_upper_limit_low};
	assign cmp_bus.lower = {window_lower_limit_high, window_lower_limit_low};
	assign cmp_bus.diff  = diff_mode_in;

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------

	// Start comes from a busy-bit write or, in other modes, from the start strobe.
	assign write_control = sfr_wr_in && (sfr_addr_in == window_det_pkg::ADDR_CONTROL);
	always_comb begin
		if (start_mode == window_det_pkg::START_ON_WRITE) begin
			start_request = write_control && sfr_wdata_in[window_det_pkg::CTRL_BUSY_BIT];
		end else begin
			start_request = conv_start_in;
		end
	end

	// Converter clock is one enable pulse every divider + 1 system clocks.
	assign sar_tick = (state == window_det_pkg::ST_CONVERT) && (div_count == divider);
	assign clocks_needed = track_mode
		? window_det_pkg::CONVERT_CLOCKS + window_det_pkg::TRACK_CLOCKS
		: window_det_pkg::CONVERT_CLOCKS;
	assign finish = sar_tick && (clock_count == clocks_needed - 4'h1);

	// Next state of the sequencer and its counters.
	always_comb begin
		next_state       = state;
		next_div_count   = div_count;
		next_clock_count = clock_count;
		case (state)
			window_det_pkg::ST_IDLE: begin
				next_div_count   = 5'h00;
				next_clock_count = 4'h0;
				if (enable && start_request) begin
					next_state = window_det_pkg::ST_CONVERT;
				end
			end
			window_det_pkg::ST_CONVERT: begin
				if (!enable) begin
					next_state = window_det_pkg::ST_IDLE;
				end else if (finish) begin
					next_state = window_det_pkg::ST_IDLE;
				end else if (sar_tick) begin
					next_div_count   = 5'h00;
					next_clock_count = clock_count + 4'h1;
				end else begin
					next_div_count = div_count + 5'h01;
				end
			end
			default: begin
				next_state = window_det_pkg::ST_IDLE;
			end
		endcase
	end

	// Sequencer registers.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state       <= window_det_pkg::ST_IDLE;
			div_count   <= 5'h00;
			clock_count <= 4'h0;
		end else begin
			state       <= next_state;
			div_count   <= next_div_count;
			clock_count <= next_clock_count;
		end
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------

	// Writes, result capture, flags with set winning over clear, and read data.
	always_comb begin
		next_window_upper_limit_high = window_upper_limit_high;
		next_window_upper_limit_low  = window_upper_limit_low;
		next_window_lower_limit_high = window_lower_limit_high;
		next_window_lower_limit_low  = window_lower_limit_low;
		next_result_high_byte        = result_high_byte;
		next_result_low_byte         = result_low_byte;
		next_divider                 = divider;
		next_left_justify_select     = left_justify_select;
		next_enable                  = enable;
		next_track_mode              = track_mode;
		next_start_mode              = start_mode;
		next_done_flag               = done_flag;
		next_window_match_flag       = window_match_flag;
		next_rdata                   = rdata;
		if (sfr_wr_in) begin
			if (sfr_addr_in == window_det_pkg::ADDR_UPPER_HIGH) begin
				next_window_upper_limit_high = sfr_wdata_in;
			end else if (sfr_addr_in == window_det_pkg::ADDR_UPPER_LOW) begin
				next_window_upper_limit_low = sfr_wdata_in;
			end else if (sfr_addr_in == window_det_pkg::ADDR_LOWER_HIGH) begin
				next_window_lower_limit_high = sfr_wdata_in;
			end else if (sfr_addr_in == window_det_pkg::ADDR_LOWER_LOW) begin
				next_window_lower_limit_low = sfr_wdata_in;
			end else if (sfr_addr_in == window_det_pkg::ADDR_CONFIG) begin
				next_divider = sfr_wdata_in[7:window_det_pkg::CFG_DIVIDER_LSB];
				next_left_justify_select = sfr_wdata_in[window_det_pkg::CFG_JUSTIFY_BIT];
			end else if (sfr_addr_in == window_det_pkg::ADDR_CONTROL) begin
				next_enable            = sfr_wdata_in[window_det_pkg::CTRL_ENABLE_BIT];
				next_track_mode        = sfr_wdata_in[window_det_pkg::CTRL_TRACK_BIT];
				next_start_mode        = sfr_wdata_in[2:0];
				next_done_flag         = sfr_wdata_in[window_det_pkg::CTRL_DONE_BIT];
				next_window_match_flag = sfr_wdata_in[window_det_pkg::CTRL_WINDOW_BIT];
			end
		end
		// A finishing conversion stores the result and judges it in the same edge.
		if (finish) begin
			next_result_high_byte = formatted[15:8];
			next_result_low_byte  = formatted[7:0];
			next_done_flag        = 1'b1;
			if (cmp_bus.match) begin
				next_window_match_flag = 1'b1;
			end
		end
		if (sfr_rd_in) begin
			if (sfr_addr_in == window_det_pkg::ADDR_UPPER_HIGH) begin
				next_rdata = window_upper_limit_high;
			end else if (sfr_addr_in == window_det_pkg::ADDR_UPPER_LOW) begin
				next_rdata = window_upper_limit_low;
			end else if (sfr_addr_in == window_det_pkg::ADDR_LOWER_HIGH) begin
				next_rdata = window_lower_limit_high;
			end else if (sfr_addr_in == window_det_pkg::ADDR_LOWER_LOW) begin
				next_rdata = window_lower_limit_low;
			end else if (sfr_addr_in == window_det_pkg::ADDR_RESULT_HIGH) begin
				next_rdata = result_high_byte;
			end else if (sfr_addr_in == window_det_pkg::ADDR_RESULT_LOW) begin
				next_rdata = result_low_byte;
			end else if (sfr_addr_in == window_det_pkg::ADDR_CONFIG) begin
				next_rdata = {divider, left_justify_select, 2'b00};
			end else if (sfr_addr_in == window_det_pkg::ADDR_CONTROL) begin
				next_rdata = {enable, track_mode, done_flag, busy_out,
					window_match_flag, start_mode};
			end else begin
				next_rdata = window_det_pkg::READ_UNMAPPED;
			end
		end
	end

	// Register file flip-flops.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			window_upper_limit_high <= window_det_pkg::RESET_BYTE;
			window_upper_limit_low  <= window_det_pkg::RESET_BYTE;
			window_lower_limit_high <= window_det_pkg::RESET_BYTE;
			window_lower_limit_low  <= window_det_pkg::RESET_BYTE;
			result_high_byte        <= window_det_pkg::RESET_BYTE;
			result_low_byte         <= window_det_pkg::RESET_BYTE;
			divider                 <= window_det_pkg::RESET_CONFIG[7:3];
			left_justify_select     <= 1'b0;
			enable                  <= 1'b0;
			track_mode              <= 1'b0;
			start_mode              <= 3'h0;
			done_flag               <= 1'b0;
			window_match_flag       <= 1'b0;
			rdata                   <= window_det_pkg::RESET_BYTE;
		end else begin
			window_upper_limit_high <= next_window_upper_limit_high;
			window_upper_limit_low  <= next_window_upper_limit_low;
			window_lower_limit_high <= next_window_lower_limit_high;
			window_lower_limit_low  <= next_window_lower_limit_low;
			result_high_byte        <= next_result_high_byte;
			result_low_byte         <= next_result_low_byte;
			divider                 <= next_divider;
			left_justify_select     <= next_left_justify_select;
			enable                  <= next_enable;
			track_mode              <= next_track_mode;
			start_mode              <= next_start_mode;
			done_flag               <= next_done_flag;
			window_match_flag       <= next_window_match_flag;
			rdata                   <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	// Busy follows the sequencer state; data and flag come from flip-flops.
	assign busy_out         = (state == window_det_pkg::ST_CONVERT);
	assign window_match_out = window_match_flag;
	assign sfr_rdata_out    = rdata;

endmodule // adc_result_window_detector

// ### dv/window_det_sva.sv
// Concurrent checks on the window detector ports.
`timescale 1ns/10ps
module window_det_sva (
	input wire logic       clk_in,
	input wire logic       rst_n_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic       sfr_wr_in,
	input wire logic       sfr_rd_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic       busy_out,
	input wire logic       window_match_out
);
	// ----------------------------------------------------------------
	// Shadow of software writes.
	// ----------------------------------------------------------------
	logic [7:0] up_hi;
	logic [7:0] lo_lo;
	logic       enable;
	logic       ctl_wr;
	logic       ctl_set;

	// Control writes, and those that set the window flag by hand.
	assign ctl_wr = sfr_wr_in && sfr_addr_in == 8'he8;
	assign ctl_set = ctl_wr && sfr_wdata_in[3];

	// Keeps the bytes the read checks need and the enable bit.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			up_hi <= 8'h00;
			lo_lo <= 8'h00;
			enable <= 1'b0;
		end else if (sfr_wr_in) begin
			case (sfr_addr_in)
				8'hc6: up_hi <= sfr_wdata_in;
				8'hc3: lo_lo <= sfr_wdata_in;
				8'he8: enable <= sfr_wdata_in[7];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	upper_read_a: assert property (sfr_rd_in && sfr_addr_in == 8'hc6
		|=> sfr_rdata_out == $past(up_hi)) else $error("upper limit byte read wrong");
	lower_read_a: assert property (sfr_rd_in && sfr_addr_in == 8'hc3
		|=> sfr_rdata_out == $past(lo_lo)) else $error("lower limit byte read wrong");
	flag_bit_a: assert property (sfr_rd_in && sfr_addr_in == 8'he8
		|=> sfr_rdata_out[3] == $past(window_match_out)) else $error("flag bit read wrong");
	flag_source_a: assert property ($rose(window_match_out)
		|-> $fell(busy_out) || $past(ctl_set)) else $error("flag rose without a result");
	flag_hold_a: assert property (window_match_out && !ctl_wr
		|=> window_match_out) else $error("flag dropped without a clear");
	flag_clear_a: assert property (ctl_wr && !sfr_wdata_in[3] && !busy_out
		|=> !window_match_out) else $error("flag not cleared");
	conv_length_a: assert property ($rose(busy_out)
		|-> busy_out[*8] ##1 busy_out[*2]) else $error("conversion too short");
	start_busy_a: assert property (ctl_wr && sfr_wdata_in[4] && sfr_wdata_in[2:0] == 3'h0
		&& enable && !busy_out |=> busy_out) else $error("write start ignored");

	cover property ($fell(busy_out) && window_match_out);
	cover property ($rose(window_match_out));
	cover property (window_match_out && ctl_wr && !sfr_wdata_in[3]);
endmodule // window_det_sva

bind adc_result_window_detector window_det_sva chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
	.sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in),
	.sfr_rd_in(sfr_rd_in), .sfr_rdata_out(sfr_rdata_out), .busy_out(busy_out),
	.window_match_out(window_match_out));

// ### dv/conv_source_model.sv
// Behavioural model of the converter result path feeding raw codes.
`timescale 1ns/10ps
module conv_source_model (
	input  wire logic       clk_in,
	input  wire logic       busy_in,
	input  wire logic [9:0] code_in,
	output logic      [9:0] sample_out
);
	// The code is settled only while converting; otherwise it churns each cycle.
	initial sample_out = 10'h155;
	always @(posedge clk_in) begin
		if (busy_in) begin
			sample_out <= code_in;
		end else begin
			sample_out <= ~sample_out;
		end
	end
endmodule // conv_source_model

// ### dv/adc_result_window_detector_test.sv
// Self-checking bench of the converter result window detector.
`timescale 1ns/10ps
module adc_result_window_detector_test;
	logic       clk_in, rst_n_in, sfr_wr_in, sfr_rd_in, conv_start_in, diff_mode_in;
	logic       busy_out, window_match_out, left;
	logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out;
	logic [9:0] sample_in, code;
	int         fails, n_tests;

	// System clock of 50 ns.
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	// Device and converter model.
	adc_result_window_detector uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in),
		.sfr_rd_in(sfr_rd_in), .sfr_rdata_out(sfr_rdata_out), .conv_start_in(conv_start_in),
		.diff_mode_in(diff_mode_in), .sample_in(sample_in), .busy_out(busy_out),
		.window_match_out(window_match_out));
	conv_source_model src (.clk_in(clk_in), .busy_in(busy_out), .code_in(code),
		.sample_out(sample_in));

	// ----------------------------------------------------------------
	// Shared tasks.
	// ----------------------------------------------------------------
	// Compares one byte and counts it.
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic end_of_test();
		$display("mismatches %0d checks %0d", fails, n_tests);
		if (fails == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// One register write.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		sfr_addr_in = a;
		sfr_wdata_in = d;
		sfr_wr_in = 1'b1;
		@(negedge clk_in);
		sfr_wr_in = 1'b0;
	endtask

	// One register read, compared with the expected byte.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_in);
		sfr_addr_in = a;
		sfr_rd_in = 1'b1;
		@(negedge clk_in);
		sfr_rd_in = 1'b0;
		check(sfr_rdata_out, exp);
	endtask

	// Starts a conversion by a control write and waits for its end.
	task automatic start(input logic [7:0] ctl);
		int i;
		wr(8'he8, ctl);
		for (i = 0; i < 100 && busy_out !== 1'b0; i++) begin
			@(negedge clk_in);
		end
		if (busy_out !== 1'b0) begin
			fails++;
			$display("MISMATCH %0t conversion hung", $time);
			end_of_test();
		end
	endtask

	// Loads the limits, converts one code, checks flag and stored word.
	task automatic run(input logic [15:0] up, input logic [15:0] lo, input logic dm,
			input logic [9:0] c, input logic hit);
		logic [15:0] w;
		w = left ? {c, 6'h00} : {{6{c[9]}}, c};
		wr(8'hc6, up[15:8]);
		wr(8'hc5, up[7:0]);
		wr(8'hc4, lo[15:8]);
		wr(8'hc3, lo[7:0]);
		diff_mode_in = dm;
		code = c;
		start(8'h90);
		check({7'h00, window_match_out}, {7'h00, hit});
		rd(8'hbe, w[15:8]);
		rd(8'hbd, w[7:0]);
	endtask

	// ----------------------------------------------------------------
	// Scenarios.
	// ----------------------------------------------------------------
	// Reset values, read-back and an unmapped read.
	task automatic reset_access();
		rd(8'hc6, 8'h00);
		rd(8'hc5, 8'h00);
		rd(8'hc4, 8'h00);
		rd(8'hc3, 8'h00);
		rd(8'h10, 8'h00);
		rd(8'hbc, 8'hf8);
		rd(8'he8, 8'h00);
		wr(8'hc6, 8'ha5);
		wr(8'hc3, 8'h3c);
		rd(8'hc6, 8'ha5);
		rd(8'hc3, 8'h3c);
		wr(8'hbc, 8'h00);
		wr(8'he8, 8'h80);
	endtask

	// Single-ended windows, edges included.
	task automatic window_single();
		run(16'h0080, 16'h0040, 1'b0, 10'h041, 1'b1);
		run(16'h0080, 16'h0040, 1'b0, 10'h040, 1'b0);
		run(16'h0080, 16'h0040, 1'b0, 10'h080, 1'b0);
		run(16'h0040, 16'h0080, 1'b0, 10'h03f, 1'b1);
		run(16'h0040, 16'h0080, 1'b0, 10'h060, 1'b0);
		run(16'h0040, 16'h0080, 1'b0, 10'h081, 1'b1);
		run(16'h0050, 16'h0050, 1'b0, 10'h050, 1'b0);
	endtask

	// Signed windows around minus one.
	task automatic window_diff();
		run(16'h0040, 16'hffff, 1'b1, 10'h000, 1'b1);
		run(16'h0040, 16'hffff, 1'b1, 10'h3ff, 1'b0);
		run(16'h0040, 16'hffff, 1'b1, 10'h200, 1'b0);
		run(16'hffff, 16'h0040, 1'b1, 10'h3fe, 1'b1);
		run(16'hffff, 16'h0040, 1'b1, 10'h000, 1'b0);
	endtask

	// The flag survives a later miss until cleared.
	task automatic flag_sticky();
		run(16'h0080, 16'h0040, 1'b0, 10'h050, 1'b1);
		rd(8'he8, 8'ha8);
		code = 10'h010;
		start(8'hb8);
		check({7'h00, window_match_out}, 8'h01);
		wr(8'he8, 8'h80);
		check({7'h00, window_match_out}, 8'h00);
	endtask

	// Left-justified words.
	task automatic left_words();
		wr(8'hbc, 8'h04);
		left = 1'b1;
		run(16'h9000, 16'h8000, 1'b0, 10'h201, 1'b1);
		run(16'h9000, 16'h8000, 1'b0, 10'h1ff, 1'b0);
		wr(8'hbc, 8'h00);
		left = 1'b0;
	endtask

	// Starts by the strobe with the given control byte and counts busy cycles.
	task automatic timed(input logic [7:0] ctl, input logic [7:0] exp);
		int n;
		n = 0;
		wr(8'he8, ctl);
		conv_start_in = 1'b1;
		@(negedge clk_in);
		conv_start_in = 1'b0;
		while (busy_out === 1'b1 && n < 100) begin
			n++;
			@(negedge clk_in);
		end
		if (n >= 100) begin
			fails++;
			$display("MISMATCH %0t conversion hung", $time);
			end_of_test();
		end
		check(n[7:0], exp);
		wr(8'he8, 8'h80);
	endtask

	// External starts: ten converter clocks, thirteen with tracking, twice as long at divider one.
	task automatic ext_timing();
		timed(8'h81, 8'h0a);
		timed(8'hc1, 8'h0d);
		wr(8'hbc, 8'h08);
		timed(8'h81, 8'h14);
		wr(8'hbc, 8'h00);
	endtask

	// Main sequence.
	initial begin
		{sfr_wr_in, sfr_rd_in, conv_start_in, diff_mode_in, left} = 5'h00;
		sfr_addr_in = 8'h00;
		sfr_wdata_in = 8'h00;
		code = 10'h000;
		fails = 0;
		n_tests = 0;
		rst_n_in = 1'b0;
		repeat (5) @(posedge clk_in);
		@(negedge clk_in);
		rst_n_in = 1'b1;
		reset_access();
		window_single();
		window_diff();
		flag_sticky();
		left_words();
		ext_timing();
		end_of_test();
	end
endmodule // adc_result_window_detector_test
